// File: shared/sse_pkg.sv
// constants, field layouts and carrier types for the three-instruction execute block
// assumes a 14-bit instruction word and 8-bit data path on one instruction clock
package sse_pkg;

  // ----------------------------------------------------------------
  // instruction word layout
  // ----------------------------------------------------------------
  localparam int IW_W      = 14;            // instruction width
  localparam int DW        = 8;             // data width
  localparam int AW        = 7;             // file address width
  localparam int OPC_HI    = 13;            // opcode field top bit
  localparam int OPC_LO    = 8;             // opcode field bottom bit
  localparam int DST_BIT   = 7;             // destination-select bit
  localparam int NIB_W     = 4;             // nibble width

  localparam logic [5:0]  OPC_SUB    = 6'h02;   // 00 0010 dfff ffff
  localparam logic [5:0]  OPC_SWAP   = 6'h0E;   // 00 1110 dfff ffff
  localparam logic [10:0] DIRLD_PAT  = 11'h00C; // 00 0000 0110 0 + fff
  localparam int          DIRLD_LO   = 3;       // pattern starts above fff

  // ----------------------------------------------------------------
  // direction registers
  // ----------------------------------------------------------------
  localparam logic [2:0] DIR_FIRST = 3'h5;  // lowest valid selector
  localparam logic [2:0] DIR_LAST  = 3'h7;  // highest valid selector
  localparam int         DIR_N     = 3;     // number of direction registers
  localparam logic [7:0] DIR_RESET = 8'hFF; // all pins input after reset
  localparam logic [7:0] ZERO8     = 8'h00; // cleared byte

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic z;                                // zero flag
    logic digit_carry;                      // digit carry flag
    logic c;                                // carry flag
  } sse_flags_t;

  typedef struct packed {
    logic          we;                      // one-cycle write strobe
    logic [AW-1:0] addr;                    // file address
    logic [DW-1:0] data;                    // write data
  } sse_fwr_t;

  // slot index of a direction selector 5..7
  function automatic logic [1:0] sse_dir_idx(input logic [2:0] sel);
    sse_dir_idx = 2'(sel - DIR_FIRST);
  endfunction

endpackage

// File: design/sse_exec.sv
// execute stage for subtract_acc_from_file, nibble_swap_file and direction_load
// assumes file operand and accumulator arrive on the same clock as the instruction
// the register file and the accumulator themselves live outside this block
module sse_exec
  import sse_pkg::*;
(
  input  wire logic            mclk_in,        // instruction clock
  input  wire logic            resetn_in,      // sync reset, low active
  input  wire logic            exec_valid_in,  // instruction present this cycle
  input  wire logic [IW_W-1:0] instr_in,       // instruction word
  input  wire logic [DW-1:0]   acc_in,         // accumulator value
  input  wire logic [DW-1:0]   file_rdata_in,  // addressed file register value
  input  wire logic            dir_wr_in,      // direct direction write strobe
  input  wire logic [2:0]      dir_sel_in,     // direct access selector 5..7
  input  wire logic [DW-1:0]   dir_wdata_in,   // direct write data
  output logic                 acc_we_out,     // accumulator write pulse
  output logic [DW-1:0]        acc_wdata_out,  // accumulator write data
  output sse_fwr_t             file_wr_out,    // file write back
  output logic                 flags_we_out,   // status write pulse
  output sse_flags_t           flags_out,      // new status flags
  output logic [DW-1:0]        dir_rdata_out,  // direct read data
  output logic [DIR_N*DW-1:0]  dir_out         // all direction registers
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [5:0]    opc      = instr_in[OPC_HI:OPC_LO];         // opcode field
  wire          dst_file = instr_in[DST_BIT];               // destination select
  wire [AW-1:0] faddr    = instr_in[AW-1:0];                // file address
  wire [2:0]    dsel     = instr_in[2:0];                   // direction selector
  // an instruction is acted on only while exec_valid_in is high;
  // any other opcode falls through with no strobe at all
  // the direction load pattern fixes the upper bits, fff picks the slot
  wire is_sub   = exec_valid_in && (opc == OPC_SUB);
  wire is_swap  = exec_valid_in && (opc == OPC_SWAP);
  wire is_dirld = exec_valid_in && (instr_in[IW_W-1:DIRLD_LO] == DIRLD_PAT)
                  && (dsel >= DIR_FIRST);
  wire dir_ok   = (dir_sel_in >= DIR_FIRST);                // direct access in range

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  // nine-bit difference keeps the borrow out in the top bit
  // a separate five-bit difference gives the low nibble borrow
  wire [DW:0]    diff   = {1'b0, file_rdata_in} - {1'b0, acc_in};
  wire [NIB_W:0] ldiff  = {1'b0, file_rdata_in[NIB_W-1:0]}
                        - {1'b0, acc_in[NIB_W-1:0]};               // low nibble borrow
  wire           neg    = diff[DW];                                // borrow out
  wire           zero   = (diff[DW-1:0] == ZERO8);
  wire [DW-1:0]  swapd  = {file_rdata_in[NIB_W-1:0],
                           file_rdata_in[DW-1:NIB_W]};

  // flag selection: zero forces all set, negative forces all clear
  sse_flags_t sub_flags;
  assign sub_flags.z  = zero && !neg;
  assign sub_flags.c  = !neg;
  // a negative result never has a zero low byte, so zero and neg
  // are exclusive and the flag cases do not overlap
  assign sub_flags.digit_carry = neg ? 1'b0 : (zero ? 1'b1 : !ldiff[NIB_W]);

  wire [DW-1:0] result  = is_sub ? diff[DW-1:0] : swapd;           // datapath mux
  wire          do_res  = is_sub || is_swap;                       // result produced

  // ----------------------------------------------------------------
  // result and flag registers, one cycle per instruction
  // ----------------------------------------------------------------
  // strobes are one-cycle pulses; data reload on every cycle, flags hold until the next subtract
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      acc_we_out    <= 1'b0;
      acc_wdata_out <= ZERO8;
      file_wr_out   <= '0;
      flags_we_out  <= 1'b0;
      flags_out     <= '0;
    end else begin
      acc_we_out       <= do_res && !dst_file;
      file_wr_out.we   <= do_res && dst_file;
      file_wr_out.addr <= faddr;
      file_wr_out.data <= result;
      acc_wdata_out    <= result;
      flags_we_out     <= is_sub;
      // swap and direction load leave the flags as they are
      if (is_sub) begin
        flags_out <= sub_flags;
      end
    end
  end

  // ----------------------------------------------------------------
  // direction registers
  // ----------------------------------------------------------------
  // slot index is the selector minus five, cut to two bits; selectors below five
  // wrap to indices 0..3 and are kept off by dir_ok and the range test
  logic [DW-1:0] dir_reg [DIR_N];                                  // storage
  wire  [1:0]    ld_idx = sse_dir_idx(dsel);                       // instruction slot
  wire  [1:0]    wr_idx = sse_dir_idx(dir_sel_in);                 // direct slot

  // direct write wins over a same-cycle direction load
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      // every slot comes up as all inputs
      for (int i = 0; i < DIR_N; i++) begin
        dir_reg[i] <= DIR_RESET;
      end
    end else if (dir_wr_in && dir_ok) begin
      dir_reg[wr_idx] <= dir_wdata_in;
    end else if (is_dirld) begin
      dir_reg[ld_idx] <= acc_in;
    end
  end

  // read data and mirror outputs, registered
  // read data follows the selector with one cycle of latency
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      dir_rdata_out <= ZERO8;
      dir_out       <= {DIR_N{DIR_RESET}};
    end else begin
      dir_rdata_out <= dir_ok ? dir_reg[wr_idx] : ZERO8;
      for (int i = 0; i < DIR_N; i++) begin
        dir_out[i*DW +: DW] <= dir_reg[i];                         // slot mirror
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // all properties run on the instruction clock and are
  // switched off while reset is held
  // issue and acknowledge of one subtract, used by the timing check
  sequence sub_issue_s;
    is_sub;
  endsequence

  sequence sub_ack_s;
    ##1 (flags_we_out && (acc_we_out != file_wr_out.we));
  endsequence

  // destination bit steers the single write strobe of a subtract
  sub_dest_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    sub_issue_s |-> ##1 (file_wr_out.we == $past(dst_file)) && (acc_we_out == !$past(dst_file)))
    else $error("subtract destination wrong");

  // result is the low byte of file minus accumulator
  sub_value_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    sub_issue_s |=> (file_wr_out.data == 8'($past(file_rdata_in) - $past(acc_in))))
    else $error("subtract result wrong");

  // carry is set exactly when no borrow was needed
  carry_sense_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    sub_issue_s |=> (flags_out.c == ($past(file_rdata_in) >= $past(acc_in))))
    else $error("carry sense wrong");

  // equal operands give the all-ones flag pattern
  zero_flags_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (is_sub && file_rdata_in == acc_in) |=> (flags_out == 3'b111))
    else $error("zero result flags wrong");

  // a borrow clears every flag
  neg_flags_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (is_sub && file_rdata_in < acc_in) |=> (flags_out == 3'b000))
    else $error("negative result flags wrong");

  // swap exchanges nibbles and leaves the status alone
  swap_value_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    is_swap |=> !flags_we_out && $stable(flags_out)
      && acc_wdata_out == {$past(file_rdata_in[3:0]), $past(file_rdata_in[7:4])})
    else $error("swap result or flags wrong");

  // swap obeys the same destination bit as subtract
  swap_dest_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    is_swap |=> (file_wr_out.we == $past(dst_file)) && (acc_we_out != file_wr_out.we))
    else $error("swap destination wrong");

  // write back carries the address field of the instruction
  file_addr_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    do_res |=> (file_wr_out.addr == $past(faddr)))
    else $error("write back address wrong");

  // a loaded slot shows up on the mirror two edges later
  dir_load_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (is_dirld && !dir_wr_in) |=> ##1
      dir_out[$past(ld_idx, 2)*DW +: DW] == $past(acc_in, 2))
    else $error("direction load wrong");

  // a direction load never touches the status flags
  dir_flags_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    is_dirld |=> !flags_we_out && $stable(flags_out))
    else $error("direction load touched flags");

  // a direction load with a selector below five changes no slot
  dir_refuse_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (exec_valid_in && !dir_wr_in && (instr_in[IW_W-1:DIRLD_LO] == DIRLD_PAT)
      && (dsel < DIR_FIRST)) |=> ##1 $stable(dir_out))
    else $error("refused direction load changed a slot");

  // direct write just done reads back on the following cycle
  dir_direct_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (dir_wr_in && dir_ok) ##1 (!dir_wr_in && dir_sel_in == $past(dir_sel_in))
      |=> dir_rdata_out == $past(dir_wdata_in, 2))
    else $error("direct direction access wrong");

  // direct write beats a direction load in the same cycle
  dir_wins_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (is_dirld && dir_wr_in && dir_ok) |=> ##1
      dir_out[$past(wr_idx, 2)*DW +: DW] == $past(dir_wdata_in, 2))
    else $error("direct write lost to direction load");

  // selectors outside five to seven read as zero
  dir_bad_read_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !dir_ok |=> (dir_rdata_out == ZERO8))
    else $error("out of range read not zero");

  // subtract strobes exactly one cycle after issue
  one_cycle_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (sub_issue_s ##0 sub_ack_s) or (!is_sub ##1 !flags_we_out))
    else $error("subtract not one cycle");

  // nothing is written back unless a result instruction was taken
  idle_quiet_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !do_res |=> !acc_we_out && !file_wr_out.we && !flags_we_out)
    else $error("write strobe without an instruction");

endmodule

// File: tb/sse_exec_tb.sv
// self-checking bench for the subtract, nibble swap and direction load execute block
// assumes sse_pkg is compiled first; inputs change 5 ns after each rising edge
module sse_exec_tb
  import sse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // stimulus and observation signals
  // ----------------------------------------------------------------
  logic              mclk_in       = 1'b0;  // 20 MHz instruction clock
  logic              resetn_in     = 1'b0;  // sync reset, low active
  logic              exec_valid_in = 1'b0;  // instruction present
  logic [IW_W-1:0]   instr_in      = '0;    // instruction word
  logic [DW-1:0]     acc_in        = '0;    // accumulator value
  logic [DW-1:0]     file_rdata_in = '0;    // file operand
  logic              dir_wr_in     = 1'b0;  // direct write strobe
  logic [2:0]        dir_sel_in    = 3'h0;  // direct selector
  logic [DW-1:0]     dir_wdata_in  = '0;    // direct write data
  logic              acc_we_out;            // accumulator strobe
  logic [DW-1:0]     acc_wdata_out;         // accumulator data
  sse_fwr_t          file_wr_out;           // file write back
  logic              flags_we_out;          // status strobe
  sse_flags_t        flags_out;             // status flags: zero, digit carry, carry
  logic [DW-1:0]     dir_rdata_out;         // direct read data
  logic [DIR_N*DW-1:0] dir_out;             // all direction registers
  int                fail_count    = 0;     // mismatches seen
  int                checks        = 0;     // comparisons made
  int                cycles        = 0;     // timeout counter

  // ----------------------------------------------------------------
  // clock, timeout and design under test
  // ----------------------------------------------------------------
  always #25 mclk_in = ~mclk_in;
  // cut a hang short
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      results();
    end
  end
  sse_exec dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .exec_valid_in(exec_valid_in),
    .instr_in(instr_in), .acc_in(acc_in), .file_rdata_in(file_rdata_in),
    .dir_wr_in(dir_wr_in), .dir_sel_in(dir_sel_in), .dir_wdata_in(dir_wdata_in),
    .acc_we_out(acc_we_out), .acc_wdata_out(acc_wdata_out), .file_wr_out(file_wr_out),
    .flags_we_out(flags_we_out), .flags_out(flags_out), .dir_rdata_out(dir_rdata_out),
    .dir_out(dir_out));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  // one edge, then settle
  task automatic step();
    @(posedge mclk_in);
    #5;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // present one instruction for one edge, left asserted for back to back use
  task automatic exec(input logic [13:0] iw, input logic [7:0] acc, input logic [7:0] fv);
    exec_valid_in = 1'b1;
    instr_in      = iw;
    acc_in        = acc;
    file_rdata_in = fv;
    step();
  endtask
  // verdict and end of run
  task automatic results();
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // subtract: positive to file, negative and zero to accumulator
  task automatic t_subtract();
    exec({OPC_SUB, 1'b1, 7'h03}, 8'h02, 8'h03);
    chk(file_wr_out, {1'b1, 7'h03, 8'h01});
    chk({acc_we_out, flags_we_out, flags_out}, {1'b0, 1'b1, 3'b011});
    exec({OPC_SUB, 1'b0, 7'h00}, 8'h02, 8'h01);
    chk({acc_we_out, acc_wdata_out, file_wr_out.we}, {1'b1, 8'hFF, 1'b0});
    chk(flags_out, 3'b000);
    exec({OPC_SUB, 1'b0, 7'h7F}, 8'h02, 8'h02);
    chk({acc_we_out, acc_wdata_out, flags_we_out}, {1'b1, 8'h00, 1'b1});
    chk(flags_out, 3'b111);
  endtask
  // swap back to back, flags held from the last subtract
  task automatic t_swap();
    exec({OPC_SWAP, 1'b0, 7'h10}, 8'h33, 8'hA5);
    chk({acc_we_out, acc_wdata_out, flags_we_out}, {1'b1, 8'h5A, 1'b0});
    exec({OPC_SWAP, 1'b1, 7'h45}, 8'h33, 8'h0F);
    chk({acc_we_out, file_wr_out}, {1'b0, 1'b1, 7'h45, 8'hF0});
    chk({flags_we_out, flags_out}, {1'b0, 3'b111});
    exec_valid_in = 1'b0;
    step();
    chk({acc_we_out, file_wr_out.we, flags_we_out}, 3'b000);
  endtask
  // direction load: refused below 5, accepted at 6
  task automatic t_dirload();
    exec({DIRLD_PAT, 3'h4}, 8'h55, 8'h00);
    chk({acc_we_out, file_wr_out.we, flags_we_out}, 3'b000);
    exec({DIRLD_PAT, 3'h6}, 8'h3C, 8'h00);
    chk({acc_we_out, file_wr_out.we, flags_we_out}, 3'b000);
    exec_valid_in = 1'b0;
    step();
    step();
    chk(dir_out, 24'hFF3CFF);
  endtask
  // direct write and read back, ignored selector, direct write beats a load
  task automatic t_direct();
    dir_wr_in    = 1'b1;
    dir_sel_in   = 3'h7;
    dir_wdata_in = 8'h12;
    step();
    dir_wr_in = 1'b0;
    step();
    chk(dir_rdata_out, 8'h12);
    dir_wr_in    = 1'b1;
    dir_sel_in   = 3'h3;
    dir_wdata_in = 8'h00;
    step();
    dir_wr_in  = 1'b0;
    dir_sel_in = 3'h6;
    step();
    chk({dir_out, dir_rdata_out}, {24'h123CFF, 8'h3C});
    dir_sel_in = 3'h2;
    step();
    chk(dir_rdata_out, 8'h00);
    dir_wr_in    = 1'b1;
    dir_sel_in   = 3'h5;
    dir_wdata_in = 8'h99;
    exec({DIRLD_PAT, 3'h5}, 8'h77, 8'h00);
    exec_valid_in = 1'b0;
    dir_wr_in     = 1'b0;
    step();
    step();
    chk(dir_out, 24'h123C99);
  endtask
  // mid-run reset, then a subtract on the first edge after release
  task automatic t_reset();
    resetn_in = 1'b0;
    step();
    chk({acc_we_out, acc_wdata_out, file_wr_out, flags_we_out, flags_out}, 29'h0);
    chk({dir_out, dir_rdata_out}, {24'hFFFFFF, 8'h00});
    resetn_in = 1'b1;
    exec({OPC_SUB, 1'b1, 7'h20}, 8'h01, 8'h10);
    chk({acc_we_out, file_wr_out}, {1'b0, 1'b1, 7'h20, 8'h0F});
    chk({flags_we_out, flags_out}, {1'b1, 3'b001});
    exec_valid_in = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk_in);
    #5;
    resetn_in = 1'b1;
    chk({dir_out, dir_rdata_out}, {24'hFFFFFF, 8'h00});
    t_subtract();
    t_swap();
    t_dirload();
    t_direct();
    t_reset();
    results();
  end
endmodule
